// *** core/ddr_flash_port.sv ***
`timescale 1ns/1ns
// Behaviour
// - three command words over six clock edges
// - bit 47 high reads, low writes
// - space bit ignored, single address space
// - bit 45 picks wrapped or linear burst
// - half-page address and starting word decoded
// - writes carry one word, burst bit ignored
// - write address and data go to buffer
// - high byte rising edge, low byte falling
// - select high ends transfer at any time
// - read data edge-aligned with strobe transitions
// - array access starts after second command word
// - strobe and data start after latency clocks
// - reads stream while clock keeps toggling
// - wrapped bursts cycle, linear bursts advance
// - linear read rolls over to zero
// - short wraps add no page latency
// - latency is five plus code clocks, codes above eleven give sixteen
// - hybrid does one wrap then linear
// - latency code from configuration register bits
// - reset latency code is sixteen clocks
// - reset floats pins, returns to read
module ddr_flash_port
	import flash_bus_pkg::*;
#(
	parameter int ADDR_W = 25
) (
	// system clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	// link clock and bus pins
	input wire logic clk_link_i,
	input wire logic chip_sel_n_i,
	input wire logic [7:0] dq_i,
	output logic [7:0] dq_o,
	output logic dq_oe_o,
	output logic read_data_strobe_o,
	output logic read_data_strobe_oe_o,
	// configuration register fields
	input wire logic [3:0] config_latency_i,
	input wire logic [1:0] wrap_len_i,
	input wire logic hybrid_en_i,
	// memory array read port, link domain
	output logic [ADDR_W-1:0] arr_addr_o,
	input wire logic [15:0] arr_data_i,
	// command buffer write port, system domain
	output logic cmd_wr_valid_o,
	output logic [ADDR_W-1:0] cmd_wr_addr_o,
	output logic [15:0] cmd_wr_data_o,
	// status
	output logic bus_active_o
);

	// ---------------- system domain ----------------

	logic [3:0] lat_code_ff; // config_register latency field
	logic [1:0] wrap_len_ff; // wrapped burst length
	logic hybrid_ff; // hybrid burst option
	logic [2:0] wr_tgl_sys_ff; // write toggle synchroniser plus edge stage
	logic [1:0] act_sync_ff; // select level synchroniser

	// configuration register; default latency sixteen clocks
	// latency field
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lat_code_ff <= LAT_RESET_CODE;
			wrap_len_ff <= WRAP_RESET;
			hybrid_ff <= HYBRID_RESET;
		end else if (clk_en_i) begin
			lat_code_ff <= config_latency_i;
			wrap_len_ff <= wrap_len_i;
			hybrid_ff <= hybrid_en_i;
		end
	end

	// select level brought into the system domain
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			act_sync_ff <= 2'b00;
			bus_active_o <= 1'b0;
		end else if (clk_en_i) begin
			act_sync_ff <= {act_sync_ff[0], ~chip_sel_n_i};
			bus_active_o <= act_sync_ff[1];
		end
	end

	logic wr_tgl_link_ff; // flips once per completed write word
	logic [ADDR_W-1:0] wr_addr_link_ff; // write address held at the link
	logic [15:0] wr_data_link_ff; // write data held at the link

	// write word handed to the command buffer
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_tgl_sys_ff <= 3'b000;
			cmd_wr_valid_o <= 1'b0;
			cmd_wr_addr_o <= '0;
			cmd_wr_data_o <= 16'h0000;
		end else if (clk_en_i) begin
			wr_tgl_sys_ff <= {wr_tgl_sys_ff[1:0], wr_tgl_link_ff};
			cmd_wr_valid_o <= wr_tgl_sys_ff[2] ^ wr_tgl_sys_ff[1];
			// link words are stable for many cycles around the toggle
			if (wr_tgl_sys_ff[2] ^ wr_tgl_sys_ff[1]) begin
				cmd_wr_addr_o <= wr_addr_link_ff;
				cmd_wr_data_o <= wr_data_link_ff;
			end
		end
	end

	// ---------------- link domain ----------------

	// select high ends and clears the transaction
	logic link_rst_n;
	assign link_rst_n = rstn_i & ~chip_sel_n_i;

	logic [1:0] en_sync_ff; // clock enable synchroniser
	logic [7:0] lat_sync_ff; // two stages of latency code
	logic [3:0] wrap_sync_ff; // two stages of wrap length
	logic [1:0] hyb_sync_ff; // two stages of hybrid option

	// quasi-static configuration crossed into the link clock
	always_ff @(posedge clk_link_i or negedge rstn_i) begin
		if (!rstn_i) begin
			en_sync_ff <= 2'b00;
			lat_sync_ff <= {LAT_RESET_CODE, LAT_RESET_CODE};
			wrap_sync_ff <= {WRAP_RESET, WRAP_RESET};
			hyb_sync_ff <= {HYBRID_RESET, HYBRID_RESET};
		end else begin
			en_sync_ff <= {en_sync_ff[0], clk_en_i};
			lat_sync_ff <= {lat_sync_ff[3:0], lat_code_ff};
			wrap_sync_ff <= {wrap_sync_ff[1:0], wrap_len_ff};
			hyb_sync_ff <= {hyb_sync_ff[0], hybrid_ff};
		end
	end

	logic link_en;
	assign link_en = en_sync_ff[1];

	// latency clocks, reserved codes fall back to the longest
	logic [4:0] lat_clks;
	always_comb begin
		if (lat_sync_ff[7:4] > LAT_CODE_MAX) begin
			lat_clks = LAT_BASE_CLKS + {1'b0, LAT_CODE_MAX};
		end else begin
			lat_clks = LAT_BASE_CLKS + {1'b0, lat_sync_ff[7:4]};
		end
	end

	// wrap mask for the configured burst length
	logic [4:0] wrap_mask;
	always_comb begin
		case (wrap_sync_ff[3:2])
			WRAP_32B: wrap_mask = WRAP_MASK_32B;
			WRAP_64B: wrap_mask = WRAP_MASK_64B;
			default: wrap_mask = WRAP_MASK_16B;
		endcase
	end

	link_state_e state_ff; // transaction phase
	logic [1:0] cnt_ff; // command clock count
	logic [4:0] lat_ff; // latency clocks remaining
	logic [7:0] hi_ff; // byte taken on the rising edge
	logic [7:0] dq_pos_ff; // rising half of the data encoder
	logic [7:0] dq_neg_ff; // falling half of the data encoder
	logic read_data_strobe_pos_ff; // rising half of the strobe encoder
	logic read_data_strobe_neg_ff; // falling half of the strobe encoder
	logic [15:0] ca0_ff; // cmd_addr_word_first
	logic [15:0] ca1_ff; // cmd_addr_word_second
	logic linear_ff; // burst now advancing linearly
	logic [4:0] wrap_cnt_ff; // words sent in the first wrap

	// data and strobe change on both link clock edges while reading
	assign dq_o = dq_pos_ff ^ dq_neg_ff;
	assign read_data_strobe_o = read_data_strobe_pos_ff ^ read_data_strobe_neg_ff;

	// rising-edge phase control
	always_ff @(posedge clk_link_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state_ff <= LS_CMD;
			cnt_ff <= 2'h0;
			lat_ff <= 5'h00;
			hi_ff <= 8'h00;
		end else if (link_en) begin
			// high byte on the rising edge
			hi_ff <= dq_i;
			case (state_ff)
				LS_CMD: begin
					if (cnt_ff == CNT_CA2) begin
						if (ca0_ff[CA_RW_BIT - 32]) begin
							state_ff <= LS_LAT;
							lat_ff <= lat_clks - 5'h01;
						end else begin
							state_ff <= LS_WDATA;
						end
					end else begin
						cnt_ff <= cnt_ff + 2'h1;
					end
				end
				// initial latency only, never a page stall
				LS_LAT: begin
					if (lat_ff == 5'h00) begin
						state_ff <= LS_RDATA;
					end else begin
						lat_ff <= lat_ff - 5'h01;
					end
				end
				LS_RDATA: state_ff <= LS_RDATA;
				// one write word, later clocks ignored
				LS_WDATA: state_ff <= LS_IGNORE;
				default: state_ff <= LS_IGNORE;
			endcase
		end
	end

	logic rd_phase;
	assign rd_phase = (state_ff == LS_RDATA) || (state_ff == LS_LAT && lat_ff == 5'h00);

	// pins driven from the first data edge until select rises
	always_ff @(posedge clk_link_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			dq_oe_o <= 1'b0;
			read_data_strobe_oe_o <= 1'b0;
			dq_pos_ff <= 8'h00;
			read_data_strobe_pos_ff <= 1'b0;
		end else if (link_en && rd_phase) begin
			dq_oe_o <= 1'b1;
			read_data_strobe_oe_o <= 1'b1;
			// high byte with the rising strobe
			dq_pos_ff <= arr_data_i[15:8] ^ dq_neg_ff;
			read_data_strobe_pos_ff <= ~read_data_strobe_neg_ff;
		end
	end

	// falling-edge half of the read encoder
	always_ff @(negedge clk_link_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			dq_neg_ff <= 8'h00;
			read_data_strobe_neg_ff <= 1'b0;
		end else if (link_en && state_ff == LS_RDATA) begin
			// low byte with the falling strobe
			dq_neg_ff <= arr_data_i[7:0] ^ dq_pos_ff;
			read_data_strobe_neg_ff <= read_data_strobe_pos_ff;
		end
	end

	// start word address from all three command words
	logic [ADDR_W-1:0] start_addr;
	assign start_addr = ADDR_W'({ca0_ff[CA_SPACE_BIT - 32 - 1:0], ca1_ff, hi_ff, dq_i} >> CA_HPAGE_LSB << 3)
		| ADDR_W'(dq_i[CA_WORD_MSB:0]);

	logic [ADDR_W-1:0] next_addr;
	always_comb begin
		if (linear_ff) begin
			// natural rollover to zero at the top
			next_addr = arr_addr_o + ADDR_W'(1);
		end else begin
			// low bits wrap, base stays aligned
			next_addr = (arr_addr_o & ~ADDR_W'(wrap_mask)) | ((arr_addr_o + ADDR_W'(1)) & ADDR_W'(wrap_mask));
		end
	end

	// command capture and array address on the falling edge
	always_ff @(negedge clk_link_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ca0_ff <= 16'h0000;
			ca1_ff <= 16'h0000;
			arr_addr_o <= '0;
			linear_ff <= 1'b0;
			wrap_cnt_ff <= 5'h00;
		end else if (link_en) begin
			if (state_ff == LS_CMD) begin
				if (cnt_ff == CNT_CA0) begin
					ca0_ff <= {hi_ff, dq_i};
				end else if (cnt_ff == CNT_CA1) begin
					ca1_ff <= {hi_ff, dq_i};
					// array access opens on the half-page
					arr_addr_o <= ADDR_W'({ca0_ff[CA_SPACE_BIT - 32 - 1:0], hi_ff, dq_i} << 3);
				end else if (cnt_ff == CNT_CA2) begin
					// space bit plays no part in decoding
					arr_addr_o <= start_addr;
					// burst kind from the first word
					linear_ff <= ca0_ff[CA_BURST_BIT - 32];
					wrap_cnt_ff <= 5'h00;
				end
			end else if (state_ff == LS_RDATA) begin
				arr_addr_o <= next_addr;
				// hybrid leaves wrapping after one full burst
				if (!linear_ff && hyb_sync_ff[1]) begin
					wrap_cnt_ff <= wrap_cnt_ff + 5'h01;
					if (wrap_cnt_ff == wrap_mask) begin
						linear_ff <= 1'b1;
						arr_addr_o <= (arr_addr_o & ~ADDR_W'(wrap_mask)) + ADDR_W'(wrap_mask) + ADDR_W'(1);
					end
				end
			end
		end
	end

	// write word capture; burst bit ignored for writes
	// address and data held for the command buffer
	always_ff @(negedge clk_link_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_tgl_link_ff <= 1'b0;
			wr_addr_link_ff <= '0;
			wr_data_link_ff <= 16'h0000;
		end else if (link_en && !chip_sel_n_i && state_ff == LS_WDATA) begin
			wr_addr_link_ff <= arr_addr_o;
			wr_data_link_ff <= {hi_ff, dq_i};
			wr_tgl_link_ff <= ~wr_tgl_link_ff;
		end
	end

endmodule

// *** core/flash_bus_pkg.sv ***
package flash_bus_pkg;

	// command/address field positions in the 48-bit word triple
	localparam int CA_RW_BIT = 47;
	localparam int CA_SPACE_BIT = 46;
	localparam int CA_BURST_BIT = 45;
	localparam int CA_HPAGE_LSB = 16;
	localparam int CA_WORD_MSB = 2;

	// posedge count at which each command word completes on the falling edge
	localparam logic [1:0] CNT_CA0 = 2'h1;
	localparam logic [1:0] CNT_CA1 = 2'h2;
	localparam logic [1:0] CNT_CA2 = 2'h3;

	// initial latency: code 0 gives this many clocks, one more per step
	localparam logic [4:0] LAT_BASE_CLKS = 5'h05;
	localparam logic [3:0] LAT_CODE_MAX = 4'hB;
	// factory default latency code, the longest setting
	localparam logic [3:0] LAT_RESET_CODE = 4'hB;

	// wrapped burst length in words, minus one, used as a mask
	localparam logic [4:0] WRAP_MASK_16B = 5'h07;
	localparam logic [4:0] WRAP_MASK_32B = 5'h0F;
	localparam logic [4:0] WRAP_MASK_64B = 5'h1F;

	// reset values of the user-side configuration
	localparam logic [1:0] WRAP_RESET = 2'h0;
	localparam logic HYBRID_RESET = 1'b0;

	// wrapped burst length selection
	typedef enum logic [1:0] {
		WRAP_16B = 2'b00,
		WRAP_32B = 2'b01,
		WRAP_64B = 2'b10
	} wrap_len_e;

	// phases of one bus transaction at the link
	typedef enum logic [2:0] {
		LS_CMD = 3'b000,
		LS_LAT = 3'b001,
		LS_RDATA = 3'b010,
		LS_WDATA = 3'b011,
		LS_IGNORE = 3'b100
	} link_state_e;

endpackage

// *** tb/ddr_flash_port_props.sv ***
`timescale 1ns/1ns
module ddr_flash_port_props #(
	parameter int ADDR_W = 25
) (
	// clocks, reset and bus pins
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic clk_link_i,
	input wire logic chip_sel_n_i,
	input wire logic [7:0] dq_i,
	input wire logic [7:0] dq_o,
	input wire logic dq_oe_o,
	input wire logic read_data_strobe_o,
	input wire logic read_data_strobe_oe_o,
	// configuration, array and buffer
	input wire logic [3:0] config_latency_i,
	input wire logic [ADDR_W-1:0] arr_addr_o,
	input wire logic cmd_wr_valid_o,
	input wire logic [ADDR_W-1:0] cmd_wr_addr_o,
	input wire logic [15:0] cmd_wr_data_o
);
	logic [9:0] cnt_ff; // link rising edges since select fell
	logic lin_ff; // linear burst asked for
	// edge count and burst kind, cleared while deselected
	always_ff @(posedge clk_link_i or posedge chip_sel_n_i) begin
		if (chip_sel_n_i) begin
			cnt_ff <= 10'h000;
			lin_ff <= 1'b0;
		end else begin
			cnt_ff <= cnt_ff + 10'h001;
			if (cnt_ff == 10'h000) lin_ff <= dq_i[5];
		end
	end
	a_idle_quiet: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		chip_sel_n_i && $past(chip_sel_n_i) |-> !dq_oe_o && !read_data_strobe_oe_o && dq_o == 8'h00)
		else $error("pins driven while deselected");
	a_oe_pair: assert property (@(posedge clk_link_i) disable iff (!rstn_i)
		dq_oe_o == read_data_strobe_oe_o)
		else $error("data and strobe enables differ");
	a_strobe_high: assert property (@(negedge clk_link_i) disable iff (!rstn_i || chip_sel_n_i)
		read_data_strobe_oe_o |-> read_data_strobe_o)
		else $error("strobe low after rising data edge");
	a_strobe_low: assert property (@(posedge clk_link_i) disable iff (!rstn_i || chip_sel_n_i)
		read_data_strobe_oe_o |-> !read_data_strobe_o)
		else $error("strobe high after falling data edge");
	a_first_data: assert property (@(negedge clk_link_i) disable iff (!rstn_i || chip_sel_n_i)
		$rose(dq_oe_o) |-> cnt_ff == (config_latency_i > 4'hB ? 10'h014 : 10'h009 + config_latency_i))
		else $error("first read data at wrong edge");
	a_linear_step: assert property (@(negedge clk_link_i) disable iff (!rstn_i || chip_sel_n_i)
		lin_ff && dq_oe_o && $past(dq_oe_o) |-> arr_addr_o == $past(arr_addr_o) + 1'b1)
		else $error("linear address did not advance by one");
	a_wr_single: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		cmd_wr_valid_o |=> !cmd_wr_valid_o [*4])
		else $error("write pulse repeated");
	a_wr_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!cmd_wr_valid_o |-> $stable(cmd_wr_addr_o) && $stable(cmd_wr_data_o))
		else $error("buffer word changed without a write");
endmodule

// *** tb/flash_host_model.sv ***
`timescale 1ns/1ns
module flash_host_model (
	// host side of the link
	output logic clk_link_o,
	output logic chip_sel_n_o,
	output logic [7:0] dq_o,
	// device answer
	input wire logic [7:0] dev_dq_i,
	input wire logic dev_oe_i,
	input wire logic dev_strobe_i
);
	logic [15:0] rd_q[$]; // words read back
	logic [7:0] hi_byte; // first byte of a word
	// clock stands low, select high
	initial begin
		clk_link_o = 1'b0;
		chip_sel_n_o = 1'b1;
		dq_o = 8'hFF;
	end
	// one frame of n clocks: command words, one write word if ca[47] is low, then a released bus
	task automatic frame(input logic [47:0] ca, input logic [15:0] wd, input int n);
		logic [7:0] b;
		chip_sel_n_o = 1'b0;
		#3;
		for (int e = 0; e < 2 * n; e++) begin
			if (e < 6) b = ca[47 - 8 * e -: 8];
			else if (e < 8 && !ca[47]) b = wd[15 - 8 * (e - 6) -: 8];
			else b = ~b; // released bus keeps changing
			dq_o = b;
			#1;
			// top rate is safe, the array model answers with no wait
			clk_link_o = ~clk_link_o;
			#2;
			if (dev_oe_i && dev_strobe_i) hi_byte = dev_dq_i;
			if (dev_oe_i && !dev_strobe_i) rd_q.push_back({hi_byte, dev_dq_i});
		end
		chip_sel_n_o = 1'b1;
		dq_o = ~b;
		#9;
	endtask
endmodule

// *** tb/ddr_flash_port_tb_top.sv ***
`timescale 1ns/1ns
module ddr_flash_port_tb_top;
	import flash_bus_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic clk_en_i = 1'b1;
	logic [3:0] config_latency_i = 4'h0;
	logic [1:0] wrap_len_i = 2'h0;
	logic hybrid_en_i = 1'b0;
	wire logic clk_link, cs_n, dq_oe, strobe, strobe_oe, wr_valid, bus_act;
	wire logic [7:0] dq_h, dq_d;
	wire logic [24:0] arr_addr, wr_addr;
	wire logic [15:0] arr_data, wr_data;
	int miscompares = 0;
	int total_checks = 0;
	int wr_seen = 0; // write pulses seen
	int act_seen = 0; // system cycles with the bus seen active
	always #5 clk_sys_i = ~clk_sys_i;
	assign arr_data = arr_addr[15:0] ^ 16'hC3A5; // array content from address
	always @(posedge clk_sys_i) if (wr_valid === 1'b1) wr_seen++;
	always @(posedge clk_sys_i) if (bus_act === 1'b1) act_seen++;
	ddr_flash_port i_ddr_flash_port (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
		.clk_link_i(clk_link), .chip_sel_n_i(cs_n), .dq_i(dq_h), .dq_o(dq_d), .dq_oe_o(dq_oe),
		.read_data_strobe_o(strobe), .read_data_strobe_oe_o(strobe_oe), .config_latency_i(config_latency_i),
		.wrap_len_i(wrap_len_i), .hybrid_en_i(hybrid_en_i), .arr_addr_o(arr_addr), .arr_data_i(arr_data),
		.cmd_wr_valid_o(wr_valid), .cmd_wr_addr_o(wr_addr), .cmd_wr_data_o(wr_data), .bus_active_o(bus_act));
	flash_host_model i_flash_host_model (.clk_link_o(clk_link), .chip_sel_n_o(cs_n), .dq_o(dq_h),
		.dev_dq_i(dq_d), .dev_oe_i(dq_oe), .dev_strobe_i(strobe));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// set configuration, then two aborted frames let it cross
	task automatic cfg(input logic [3:0] c, input logic [1:0] wl, input logic h);
		@(posedge clk_sys_i);
		config_latency_i <= c;
		wrap_len_i <= wl;
		hybrid_en_i <= h;
		repeat (2) i_flash_host_model.frame(48'h0, 16'h0, 2);
	endtask
	// read n words from {hp, w}; m is the wrap mask, zero for linear
	task automatic rd(input logic [21:0] hp, input logic [2:0] w, input logic [24:0] m, input int lat, input int n);
		logic [24:0] a;
		a = {hp, w};
		i_flash_host_model.rd_q.delete();
		i_flash_host_model.frame({2'b10, m == 25'h0, 7'h0, hp, 13'h0, w}, 16'h0, 3 + lat + n);
		check(i_flash_host_model.rd_q.size(), n);
		for (int k = 0; k < n && k < i_flash_host_model.rd_q.size(); k++) begin
			check(i_flash_host_model.rd_q[k], a[15:0] ^ 16'hC3A5);
			if (m == 25'h0 || (hybrid_en_i && k > m)) a = a + 25'h1;
			else if (hybrid_en_i && k == m) a = (a | m) + 25'h1;
			else a = (a & ~m) | ((a + 25'h1) & m);
		end
		check(dq_oe, 1'b0);
	endtask
	task automatic t_latency();
		logic [3:0] codes[3] = '{4'h0, 4'hB, 4'hE};
		foreach (codes[i]) begin
			cfg(codes[i], 2'h0, 1'b0);
			rd(22'h12345, 3'h7, 25'h0, codes[i] > 4'hB ? 16 : 5 + codes[i], 3);
		end
		$display("test latency done");
	endtask
	task automatic t_burst();
		cfg(4'h0, 2'h0, 1'b0);
		rd(22'h3FFFFF, 3'h6, 25'h0, 5, 4);
		for (int l = 0; l < 3; l++) begin
			cfg(4'h0, l[1:0], 1'b0);
			rd(22'h0ABCD, 3'h6, (25'h8 << l) - 25'h1, 5, (8 << l) + 3);
		end
		cfg(4'h0, 2'h0, 1'b1);
		rd(22'h0ABCD, 3'h6, 25'h7, 5, 12);
		$display("test burst done");
	endtask
	// clock enable low: a full write frame must leave no word behind
	task automatic t_freeze();
		int k;
		k = wr_seen;
		@(posedge clk_sys_i);
		clk_en_i <= 1'b0;
		@(posedge clk_sys_i);
		i_flash_host_model.frame({3'b001, 7'h0, 22'h15555, 13'h0, 3'h2}, 16'h1234, 6);
		repeat (8) @(posedge clk_sys_i);
		check(wr_seen - k, 0);
		clk_en_i <= 1'b1;
		$display("test freeze done");
	endtask
	// reset in mid-burst floats data and strobe at once
	task automatic t_reset();
		cfg(4'h0, 2'h0, 1'b0);
		fork
			i_flash_host_model.frame({3'b101, 7'h0, 22'h00100, 13'h0, 3'h0}, 16'h0, 24);
			begin
				wait (dq_oe === 1'b1);
				@(posedge clk_sys_i);
				rstn_i <= 1'b0;
				@(posedge clk_sys_i);
				check(dq_oe, 1'b0);
				check(strobe_oe, 1'b0);
			end
		join
		repeat (2) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		$display("test reset done");
	endtask
	task automatic t_write();
		int k;
		int a;
		cfg(4'h0, 2'h0, 1'b0);
		k = wr_seen;
		a = act_seen;
		i_flash_host_model.frame({3'b001, 7'h0, 22'h2AAAA, 13'h0, 3'h5}, 16'hBEEF, 6);
		for (int i = 0; i < 40 && wr_seen == k; i++) @(posedge clk_sys_i);
		repeat (3) @(posedge clk_sys_i);
		check(wr_seen - k, 1);
		check(wr_addr, {22'h2AAAA, 3'h5});
		check(wr_data, 16'hBEEF);
		check(act_seen > a, 1'b1);
		repeat (2) @(posedge clk_sys_i);
		check(bus_act, 1'b0);
		$display("test write done");
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		t_latency();
		t_burst();
		t_freeze();
		t_reset();
		t_write();
		check(wr_seen, 1);
		report_and_stop();
	end
	// watchdog, far beyond the expected few microseconds
	initial begin
		#200000;
		miscompares++;
		report_and_stop();
	end
endmodule
bind ddr_flash_port ddr_flash_port_props #(.ADDR_W(ADDR_W)) i_ddr_flash_port_props (.*);
